/* File: design/spmp_pkg.sv */
// Package for the serial port block: register offsets, field positions,
// reset values and rate divisors.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
package spmp_pkg;
    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STAT_OFFSET = 4'h4;
    localparam logic [3:0] DATA_OFFSET = 4'h8;
    localparam logic [3:0] IEN_OFFSET = 4'hC;
    // ---------------------------------------------------------------
    // Control fields
    // ---------------------------------------------------------------
    localparam int CTRL_RATE2_POS = 7;
    localparam int CTRL_ENABLE_POS = 6;
    localparam int CTRL_SELECT_PIN_DISABLE_BIT_POS = 5;
    localparam int CTRL_CONTROLLER_POS = 4;
    localparam int CTRL_CPOL_POS = 3;
    localparam int CTRL_CPHA_POS = 2;
    localparam int CTRL_RATE1_POS = 1;
    localparam int CTRL_RATE0_POS = 0;
    localparam logic [7:0] CTRL_RESET = 8'h14;
    // ---------------------------------------------------------------
    // Status and interrupt enable fields
    // ---------------------------------------------------------------
    localparam int STAT_DONE_POS = 7;
    localparam int STAT_OVERRUN_POS = 6;
    localparam int STAT_FAULT_POS = 4;
    localparam int STAT_TXEMPTY_POS = 3;
    localparam int IEN_DONE_POS = 0;
    localparam int IEN_FAULT_POS = 1;
    // ---------------------------------------------------------------
    // Serial constants
    // ---------------------------------------------------------------
    localparam logic [2:0] BITS_PER_BYTE = 3'h7;
    localparam logic [6:0] HALF_DIV4 = 7'h02;
endpackage

/* File: design/spmp_top.sv */
// Serial peripheral port, controller or target, behind a Wishbone slave.
// Assumes pins from outside are asynchronous; the serial clock in target
// mode runs no faster than a quarter of the system clock.
`timescale 1ns/1ps
`default_nettype none
module spmp_top #(
    parameter int ADDR_W = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic irq_o
);
    if (ADDR_W < 4) begin : g_chk
        $error("ADDR_W must be at least 4");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} spmp_phase_type;

    typedef struct packed {
        logic [2:0] sck_s;
        logic [2:0] mosi_s;
        logic [2:0] miso_s;
        logic [2:0] ss_s;
        logic [7:0] ctrl;
        logic [1:0] ien;
        logic done;
        logic fault;
        logic overrun;
        logic stat_seen;
        logic fault_seen;
        logic [7:0] rx_data;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] shifter;
        logic [2:0] bit_cnt;
        logic busy;
        logic in_bit;
        logic [7:0] rx_sh;
        logic [1:0] samp_dly;
        logic [1:0] last_dly;
        spmp_phase_type phase;
        logic [6:0] div_cnt;
        logic sck_prev;
        logic ss_prev;
        logic sck;
        logic sck_en;
        logic mosi;
        logic mosi_en;
        logic miso;
        logic miso_en;
        logic [31:0] rdata;
        logic ack;
        logic irq;
    } spmp_state_type;

    spmp_state_type st_ff;
    spmp_state_type nxt_st;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    logic [2:0] rate;
    logic [6:0] half_div;
    logic enabled, is_ctrl, cpha, cpol, select_pin_disable_bit;
    logic ss_level, sck_level, sck_level_d, data_in;
    logic sck_rise, sck_fall, lead_edge, trail_edge;
    logic selected, bus_req, bus_take;
    logic [ADDR_W-1:0] reg_adr;

    assign rate = {st_ff.ctrl[spmp_pkg::CTRL_RATE2_POS], st_ff.ctrl[spmp_pkg::CTRL_RATE1_POS],
                   st_ff.ctrl[spmp_pkg::CTRL_RATE0_POS]};
    assign half_div = (rate == 3'h0 || rate == 3'h7) ? 7'h00 : 7'(spmp_pkg::HALF_DIV4 << (rate - 3'h1));
    assign enabled = st_ff.ctrl[spmp_pkg::CTRL_ENABLE_POS];
    assign is_ctrl = st_ff.ctrl[spmp_pkg::CTRL_CONTROLLER_POS];
    assign cpha = st_ff.ctrl[spmp_pkg::CTRL_CPHA_POS];
    assign cpol = st_ff.ctrl[spmp_pkg::CTRL_CPOL_POS];
    assign select_pin_disable_bit = st_ff.ctrl[spmp_pkg::CTRL_SELECT_PIN_DISABLE_BIT_POS];
    // A change counts only once the second and third stages agree.
    assign ss_level = (st_ff.ss_s[1] == st_ff.ss_s[2]) ? st_ff.ss_s[2] : st_ff.ss_prev;
    assign sck_level = (st_ff.sck_s[1] == st_ff.sck_s[2]) ? st_ff.sck_s[2] : st_ff.sck_prev;
    assign sck_level_d = st_ff.sck_prev;
    assign sck_rise = sck_level & ~sck_level_d;
    assign sck_fall = ~sck_level & sck_level_d;
    assign lead_edge = cpol ? sck_fall : sck_rise;
    assign trail_edge = cpol ? sck_rise : sck_fall;
    assign data_in = is_ctrl ? st_ff.miso_s[2] : st_ff.mosi_s[2];
    assign selected = (select_pin_disable_bit && cpha) ? 1'b1 : ~ss_level;
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_take = bus_req & ~st_ff.ack;
    assign reg_adr = wb_adr_i;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.sck_s = {st_ff.sck_s[1:0], sck_i};
        nxt_st.mosi_s = {st_ff.mosi_s[1:0], mosi_i};
        nxt_st.miso_s = {st_ff.miso_s[1:0], miso_i};
        nxt_st.ss_s = {st_ff.ss_s[1:0], ss_n_i};
        nxt_st.sck_prev = sck_level;
        nxt_st.ss_prev = ss_level;
        nxt_st.ack = 1'b0;
        nxt_st.samp_dly = {st_ff.samp_dly[0], 1'b0};
        nxt_st.last_dly = {st_ff.last_dly[0], 1'b0};

        // ---------------------------------------------------------------
        // Serial engine
        // ---------------------------------------------------------------
        if (!enabled) begin
            nxt_st.busy = 1'b0;
            nxt_st.phase = ST_IDLE;
            nxt_st.bit_cnt = 3'h0;
        end else if (is_ctrl) begin
            if (!select_pin_disable_bit && !ss_level) begin
                nxt_st.fault = 1'b1;
                nxt_st.ctrl[spmp_pkg::CTRL_ENABLE_POS] = 1'b0;
                nxt_st.ctrl[spmp_pkg::CTRL_CONTROLLER_POS] = 1'b0;
                nxt_st.busy = 1'b0;
                nxt_st.phase = ST_IDLE;
            end else if (!st_ff.busy) begin
                if (st_ff.tx_full && half_div != 7'h00) begin
                    nxt_st.shifter = st_ff.tx_buf;
                    nxt_st.tx_full = 1'b0;
                    nxt_st.busy = 1'b1;
                    nxt_st.bit_cnt = 3'h0;
                    nxt_st.div_cnt = 7'h00;
                    nxt_st.phase = ST_LEAD;
                    if (!cpha) begin
                        nxt_st.mosi = st_ff.tx_buf[7];
                    end
                end
            end else if (st_ff.div_cnt + 7'h01 >= half_div) begin
                nxt_st.div_cnt = 7'h00;
                nxt_st.sck = ~st_ff.sck;
                if (st_ff.phase == ST_LEAD) begin
                    nxt_st.phase = ST_TRAIL;
                    if (cpha) begin
                        nxt_st.mosi = st_ff.shifter[7];
                    end else begin
                        nxt_st.in_bit = data_in;
                        {nxt_st.samp_dly[0], nxt_st.last_dly[0]} = {1'b1, st_ff.bit_cnt == spmp_pkg::BITS_PER_BYTE};
                    end
                end else begin
                    nxt_st.phase = ST_LEAD;
                    nxt_st.shifter = {st_ff.shifter[6:0], cpha ? data_in : st_ff.in_bit};
                    if (!cpha) begin
                        nxt_st.mosi = st_ff.shifter[6];
                    end
                    {nxt_st.samp_dly[0], nxt_st.last_dly[0]} = {cpha, cpha && st_ff.bit_cnt == spmp_pkg::BITS_PER_BYTE};
                    if (st_ff.bit_cnt == spmp_pkg::BITS_PER_BYTE) begin
                        nxt_st.busy = 1'b0;
                        nxt_st.phase = ST_IDLE;
                    end else begin
                        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                    end
                end
            end else begin
                nxt_st.div_cnt = st_ff.div_cnt + 7'h01;
            end
        end else begin
            if (!selected) begin
                if (st_ff.busy || (!select_pin_disable_bit && !st_ff.ss_prev)) begin
                    nxt_st.fault = ~select_pin_disable_bit | st_ff.fault;
                end
                nxt_st.busy = 1'b0;
                nxt_st.bit_cnt = 3'h0;
            end else begin
                if (!st_ff.busy && st_ff.tx_full) begin
                    nxt_st.shifter = st_ff.tx_buf;
                    nxt_st.tx_full = 1'b0;
                end
                if (!cpha && !st_ff.busy) begin
                    nxt_st.miso = st_ff.tx_full ? st_ff.tx_buf[7] : st_ff.shifter[7];
                end
                if (lead_edge) begin
                    nxt_st.busy = 1'b1;
                    if (cpha) begin
                        nxt_st.miso = nxt_st.shifter[7];
                    end else begin
                        nxt_st.in_bit = data_in;
                    end
                end else if (trail_edge && st_ff.busy) begin
                    nxt_st.shifter = {st_ff.shifter[6:0], cpha ? data_in : st_ff.in_bit};
                    if (!cpha) begin
                        nxt_st.miso = st_ff.shifter[6];
                    end
                    if (st_ff.bit_cnt == spmp_pkg::BITS_PER_BYTE) begin
                        nxt_st.busy = 1'b0;
                        nxt_st.bit_cnt = 3'h0;
                        if (st_ff.done) begin
                            nxt_st.overrun = 1'b1;
                        end else begin
                            nxt_st.rx_data = {st_ff.shifter[6:0], cpha ? data_in : st_ff.in_bit};
                            nxt_st.done = 1'b1;
                        end
                    end else begin
                        nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                    end
                end
            end
        end

        // completion capture
        // Sampling trails the clock edge by two cycles so the input synchroniser has caught up at divide by 4.
        if (enabled && is_ctrl && st_ff.samp_dly[1]) begin
            nxt_st.rx_sh = {st_ff.rx_sh[6:0], data_in};
            if (st_ff.last_dly[1] && st_ff.done) begin
                nxt_st.overrun = 1'b1;
            end else if (st_ff.last_dly[1]) begin
                nxt_st.rx_data = {st_ff.rx_sh[6:0], data_in};
                nxt_st.done = 1'b1;
            end
        end

        // ---------------------------------------------------------------
        // Pin drivers
        // ---------------------------------------------------------------
        if (!st_ff.busy || !is_ctrl) begin
            nxt_st.sck = cpol;
        end
        nxt_st.sck_en = enabled & is_ctrl;
        nxt_st.mosi_en = enabled & is_ctrl;
        nxt_st.miso_en = enabled & ~is_ctrl & selected;

        // ---------------------------------------------------------------
        // Register bus
        // ---------------------------------------------------------------
        if (bus_take) begin
            nxt_st.ack = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            unique case (reg_adr[3:0])
                spmp_pkg::CTRL_OFFSET: begin
                    nxt_st.rdata[7:0] = st_ff.ctrl;
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_st.ctrl = wb_dat_i[7:0];
                        if (st_ff.fault_seen && !(nxt_st.fault && !st_ff.fault)) begin
                            nxt_st.fault = 1'b0;
                            nxt_st.fault_seen = 1'b0;
                        end
                    end
                end
                spmp_pkg::STAT_OFFSET: begin
                    nxt_st.rdata[spmp_pkg::STAT_DONE_POS] = st_ff.done;
                    nxt_st.rdata[spmp_pkg::STAT_OVERRUN_POS] = st_ff.overrun;
                    nxt_st.rdata[spmp_pkg::STAT_FAULT_POS] = st_ff.fault;
                    nxt_st.rdata[spmp_pkg::STAT_TXEMPTY_POS] = ~st_ff.tx_full;
                    if (!wb_we_i) begin
                        nxt_st.stat_seen = st_ff.done;
                        nxt_st.fault_seen = st_ff.fault;
                    end
                end
                spmp_pkg::DATA_OFFSET: begin
                    nxt_st.rdata[7:0] = st_ff.rx_data;
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_st.tx_buf = wb_dat_i[7:0];
                        nxt_st.tx_full = 1'b1;
                    end else if (!wb_we_i && st_ff.stat_seen) begin
                        if (nxt_st.done == st_ff.done) begin
                            nxt_st.done = 1'b0;
                            nxt_st.overrun = 1'b0;
                        end
                        nxt_st.stat_seen = 1'b0;
                    end
                end
                spmp_pkg::IEN_OFFSET: begin
                    nxt_st.rdata[1:0] = st_ff.ien;
                    if (wb_we_i && wb_sel_i[0]) begin
                        nxt_st.ien = wb_dat_i[1:0];
                    end
                end
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                end
            endcase
        end

        nxt_st.irq = (nxt_st.done & nxt_st.ien[spmp_pkg::IEN_DONE_POS])
                   | (nxt_st.fault & nxt_st.ien[spmp_pkg::IEN_FAULT_POS]);
        if (is_ctrl && select_pin_disable_bit && !st_ff.fault) begin
            nxt_st.fault = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
            st_ff.ctrl <= spmp_pkg::CTRL_RESET;
            st_ff.sck_s <= 3'h7;
            st_ff.ss_s <= 3'h7;
            st_ff.sck_prev <= 1'b1;
            st_ff.ss_prev <= 1'b1;
            st_ff.phase <= ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o = st_ff.rdata;
    assign wb_ack_o = st_ff.ack;
    assign sck_o = st_ff.sck;
    assign sck_oe = st_ff.sck_en;
    assign mosi_o = st_ff.mosi;
    assign mosi_oe = st_ff.mosi_en;
    assign miso_o = st_ff.miso;
    assign miso_oe = st_ff.miso_en;
    assign irq_o = st_ff.irq;
endmodule // spmp_top
`default_nettype wire

/* File: dv/spmp_chk.sv */
// Port checker for the serial port block, bound into spmp_top.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module spmp_chk #(
    parameter int ADDR_W = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic sck_i,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic mosi_i,
    input wire logic mosi_o,
    input wire logic mosi_oe,
    input wire logic miso_i,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic ss_n_i,
    input wire logic irq_o
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_SCK_HIGH_MIN: assert property ($rose(sck_o) |=> sck_o)
        else $error("serial clock high shorter than two cycles");
    AST_SCK_LOW_MIN: assert property ($fell(sck_o) |=> !sck_o)
        else $error("serial clock low shorter than two cycles");
    // A deselected target needs the synchroniser depth plus one before it lets go.
    AST_MISO_RELEASE: assert property (ss_n_i [*6] |-> !miso_oe)
        else $error("data out driven while deselected");
    AST_ONE_ROLE: assert property (miso_oe |-> !sck_oe && !mosi_oe)
        else $error("target and controller drive at once");
    AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !wb_ack_o && !irq_o && !sck_oe)
        else $error("outputs active right after reset");
    COV_SCK: cover property ($rose(sck_o));
    COV_TARGET: cover property ($rose(miso_oe));
    COV_IRQ: cover property ($rose(irq_o));
endmodule // spmp_chk
bind spmp_top spmp_chk #(.ADDR_W(ADDR_W)) u_chk (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_i),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe),
    .ss_n_i(ss_n_i), .irq_o(irq_o));
`default_nettype wire

/* File: dv/spmp_target_model.sv */
// Behavioural external target: phase 1, polarity 0, one byte per eight clocks.
// Assumes the serial clock idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module spmp_target_model (
    input wire logic sck,
    input wire logic mosi,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output int edge_count
);
    // ---------------------------------------------------------------
    // Shifter
    // ---------------------------------------------------------------
    logic [7:0] sh_ff;
    logic [7:0] rx_ff;
    int bit_ff;
    initial begin
        miso = 1'b1;
        rx_byte = 8'h00;
        edge_count = 0;
        bit_ff = 0;
    end
    always @(posedge sck) begin
        if (bit_ff == 0) sh_ff = tx_byte;
        miso <= sh_ff[7];
        sh_ff = {sh_ff[6:0], 1'b0};
    end
    always @(negedge sck) begin
        rx_ff = {rx_ff[6:0], mosi};
        edge_count++;
        bit_ff = (bit_ff + 1) % 8;
        // Past the frame the line is left to float, so show the inverse.
        if (bit_ff == 0) begin
            rx_byte = rx_ff;
            miso <= ~miso;
        end
    end
endmodule // spmp_target_model
`default_nettype wire

/* File: dv/test_spi_master_slave_port.sv */
// Self-checking bench: Wishbone register calls, external target model, bench-driven controller.
// Assumes spmp_top, spmp_pkg, the checker and the target model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_port;
    // ---------------------------------------------------------------
    // Stimulus and checks
    // ---------------------------------------------------------------
    localparam logic [7:0] EN = 8'h01 << spmp_pkg::CTRL_ENABLE_POS;
    localparam logic [7:0] CTL = 8'h01 << spmp_pkg::CTRL_CONTROLLER_POS;
    localparam logic [7:0] PH = 8'h01 << spmp_pkg::CTRL_CPHA_POS;
    localparam logic [7:0] DIS = 8'h01 << spmp_pkg::CTRL_SELECT_PIN_DISABLE_BIT_POS;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ss_n = 1'b1, ext_sck = 1'b0, ext_mosi = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, q, rdat;
    logic [7:0] tx_m = 8'h00, m_rx, got;
    logic ack, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq_o, m_miso;
    int m_edges, n, e0, bad_count = 0, check_count = 0;
    wire sck_bus = sck_oe ? sck_o : ext_sck;
    wire mosi_bus = mosi_oe ? mosi_o : ext_mosi;
    wire miso_bus = miso_oe ? miso_o : m_miso;
    always #20 clock = ~clock;
    spmp_top #(.ADDR_W(4)) DUT (.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck_bus),
        .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_bus), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
        .miso_i(miso_bus), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n), .irq_o(irq_o));
    spmp_target_model u_far (.sck(sck_bus), .mosi(mosi_bus), .tx_byte(tx_m), .miso(m_miso), .rx_byte(m_rx),
        .edge_count(m_edges));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge clock);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin @(posedge clock); k++; end while (ack !== 1'b1 && k < 50);
        r = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (k >= 50) chk("ack", 32'h1, 32'h0);
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        while (irq_o !== 1'b1 && k < 2000) begin @(posedge clock); k++; end
        if (k >= 2000) chk("irq wait", 32'h1, 32'h0);
    endtask
    // Bench plays the controller at eight system clocks per serial period, data changing on the rise.
    task automatic ext_xfer(input logic [7:0] d, input int nb, output logic [7:0] r);
        ss_n <= 1'b0;
        repeat (8) @(posedge clock);
        for (int i = 7; i > 7 - nb; i--) begin
            ext_sck <= 1'b1; ext_mosi <= d[i];
            repeat (4) @(posedge clock);
            ext_sck <= 1'b0;
            repeat (4) @(posedge clock);
            r[i] = miso_bus;
        end
        repeat (8) @(posedge clock);
        ss_n <= 1'b1;
        repeat (8) @(posedge clock);
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] c);
        return {24'h0, c[2], 7'h00} | {30'h0, c[1:0]} | EN | CTL | PH;
    endfunction
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        wb(0, spmp_pkg::CTRL_OFFSET, 0, q); chk("ctrl reset", {24'h0, spmp_pkg::CTRL_RESET}, q);
        wb(0, 4'h2, 0, q); chk("unmapped read", 32'h0, q);
        wb(1, spmp_pkg::IEN_OFFSET, 32'h1, q);
        for (int c = 1; c <= 6; c++) begin
            tx_m <= 8'hA5 ^ 8'(c);
            wb(1, spmp_pkg::CTRL_OFFSET, ctl(3'(c)), q);
            e0 = m_edges;
            wb(1, spmp_pkg::DATA_OFFSET, 32'h3C + c, q);
            wait_irq(n);
            chk("transfer time", 32'h1, 32'(n >= 8 * (2 << c) && n <= 8 * (2 << c) + 12));
            chk("far side byte", 32'h3C + c, {24'h0, m_rx});
            chk("clock edges", 32'h8, 32'(m_edges - e0));
            wb(0, spmp_pkg::DATA_OFFSET, 0, q); chk("rx byte", 32'hA5 ^ c, q);
            wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("done kept", 32'h1, 32'(q[7]));
            wb(0, spmp_pkg::DATA_OFFSET, 0, q);
            wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("done cleared", 32'h0, 32'(q[7]));
            chk("irq cleared", 32'h0, 32'(irq_o));
        end
        wb(1, spmp_pkg::CTRL_OFFSET, ctl(3'h1) | DIS, q);
        wb(1, spmp_pkg::IEN_OFFSET, 32'h3, q);
        ss_n <= 1'b0;
        repeat (20) @(posedge clock);
        wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("no fault when pin freed", 32'h0, 32'(q[4]));
        wb(1, spmp_pkg::CTRL_OFFSET, ctl(3'h1), q);
        repeat (12) @(posedge clock);
        chk("fault irq", 32'h1, 32'(irq_o));
        wb(0, spmp_pkg::CTRL_OFFSET, 0, q); chk("enable and controller cleared", 32'h0, q & 32'h50);
        ss_n <= 1'b1;
        wb(1, spmp_pkg::CTRL_OFFSET, PH | DIS, q);
        wb(1, spmp_pkg::CTRL_OFFSET, PH, q);
        wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("fault kept", 32'h1, 32'(q[4]));
        wb(1, spmp_pkg::CTRL_OFFSET, PH, q);
        wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("fault cleared", 32'h0, 32'(q[4]));
        wb(1, spmp_pkg::IEN_OFFSET, 32'h1, q);
        wb(1, spmp_pkg::CTRL_OFFSET, EN | PH, q);
        wb(1, spmp_pkg::DATA_OFFSET, 32'h5A, q);
        ext_xfer(8'hC3, 8, got); chk("target sent", 32'h5A, {24'h0, got});
        chk("target done irq", 32'h1, 32'(irq_o));
        ext_xfer(8'h99, 8, got); chk("late write resend", 32'hC3, {24'h0, got});
        wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("overrun", 32'h1, 32'(q[6]));
        wb(0, spmp_pkg::DATA_OFFSET, 0, q); chk("unread byte kept", 32'hC3, q);
        ext_xfer(8'hF0, 3, got);
        wb(0, spmp_pkg::STAT_OFFSET, 0, q); chk("target fault", 32'h1, 32'(q[4]));
        e0 = m_edges;
        for (int c = 0; c < 2; c++) begin
            wb(1, spmp_pkg::CTRL_OFFSET, ctl(c == 0 ? 3'h0 : 3'h7), q);
            wb(1, spmp_pkg::DATA_OFFSET, 32'h11, q);
            repeat (400) @(posedge clock);
            chk("no clock for stop code", 32'(e0), 32'(m_edges));
            chk("no done for stop code", 32'h0, 32'(irq_o));
        end
        tally_and_finish();
    end
endmodule // test_spi_master_slave_port
`default_nettype wire
